// ### bench/pel_lane_ctrl_props.sv
`timescale 1ns/10ps
module pel_lane_ctrl_props #(
    parameter int LANES = 4
) (
    input wire logic             sys_clk,
    input wire logic             nrst,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata,
    input wire logic [1:0]       tx_mode,
    input wire logic [LANES-1:0] tx_bit,
    input wire logic [LANES-1:0] tx_diff_pos,
    input wire logic [LANES-1:0] tx_lane_on,
    input wire logic [LANES-1:0] rx_diff_pos,
    input wire logic [LANES-1:0] rx_bit,
    input wire logic [LANES-1:0] rx_energy_pin,
    input wire logic [LANES-1:0] lane_energy_seen,
    input wire logic             signal_ok,
    input wire logic             loopback_on,
    input wire logic [LANES-1:0] loopback_bit,
    input wire logic             coef_req,
    input wire logic             coef_ack
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    sequence s_hi;
        (tx_diff_pos == '1) [*8];
    endsequence
    sequence s_lo;
        (tx_diff_pos == '0) [*8];
    endsequence
    property p_alert;
        (tx_mode == pel_pkg::TXM_ALERT && $past(tx_mode) != pel_pkg::TXM_ALERT) |=> s_hi ##1 s_lo;
    endproperty
    a_alert: assert property (p_alert) else $error("alert pattern wrong");
    property p_data;
        tx_mode == pel_pkg::TXM_DATA |=> tx_diff_pos == $past(tx_bit);
    endproperty
    a_data: assert property (p_data) else $error("transmit level wrong");
    property p_rx;
        $past(nrst, 4) |-> rx_bit == $past(rx_diff_pos, 3);
    endproperty
    a_rx: assert property (p_rx) else $error("received bit wrong");
    property p_ok;
        $past(nrst) |-> signal_ok == &$past(lane_energy_seen);
    endproperty
    a_ok: assert property (p_ok) else $error("signal status wrong");
    property p_wake;
        (rx_energy_pin == '1) [*8] |-> lane_energy_seen == '1;
    endproperty
    a_wake: assert property (p_wake) else $error("energy flag late");
    property p_quiet;
        tx_mode == pel_pkg::TXM_QUIET |=> tx_lane_on == '0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("transmitter on in quiet");
    property p_loop;
        loopback_on && tx_mode == pel_pkg::TXM_DATA |=> loopback_bit == $past(tx_bit);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback wrong");
    property p_coef;
        $rose(coef_req) |=> coef_ack;
    endproperty
    a_coef: assert property (p_coef) else $error("no coefficient answer");
    property p_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data outside read");
endmodule

bind pel_lane_ctrl pel_lane_ctrl_props #(.LANES(LANES)) pel_lane_ctrl_props_i (
    .sys_clk(sys_clk), .nrst(nrst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_mode(tx_mode), .tx_bit(tx_bit), .tx_diff_pos(tx_diff_pos), .tx_lane_on(tx_lane_on),
    .rx_diff_pos(rx_diff_pos), .rx_bit(rx_bit), .rx_energy_pin(rx_energy_pin),
    .lane_energy_seen(lane_energy_seen), .signal_ok(signal_ok), .loopback_on(loopback_on),
    .loopback_bit(loopback_bit), .coef_req(coef_req), .coef_ack(coef_ack)
);

// ### bench/pel_partner.sv
`timescale 1ns/10ps
module pel_partner (
    input  wire logic       sys_clk,
    input  wire logic [3:0] tx_diff_pos,
    input  wire logic [3:0] tx_lane_on,
    input  wire logic       wake,
    output logic      [3:0] rx_diff_pos,
    output logic      [3:0] rx_energy_pin
);
    logic [3:0] idle_reg = 4'h5;
    // A released lane toggles every cycle.
    always_ff @(posedge sys_clk) begin
        idle_reg <= ~idle_reg;
    end
    assign rx_diff_pos = (tx_diff_pos & tx_lane_on) | (idle_reg & ~tx_lane_on);
    assign rx_energy_pin = {4{wake}};
endmodule

// ### bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    localparam int       RESP = 16;
    logic                sys_clk = 1'b0;
    logic                nrst = 1'b0;
    logic [3:0]          reg_addr = 4'h0;
    logic [7:0]          reg_wdata = 8'h00;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic [1:0]          tx_mode = pel_pkg::TXM_DATA;
    logic                rx_mode = pel_pkg::RXM_DATA;
    logic [3:0]          tx_bit = 4'h0;
    logic                loopback_on = 1'b1;
    logic                coef_req = 1'b0;
    logic                wake = 1'b0;
    pel_pkg::pel_fault_s fault_in = 3'h0;
    logic [7:0]          reg_rdata;
    logic [3:0]          tx_diff_pos, tx_lane_on, rx_diff_pos, rx_bit, rx_energy_pin;
    logic [3:0]          lane_energy_seen, loopback_bit;
    logic                irq, signal_ok, coef_ack;
    int                  n_mismatch = 0;
    int                  comparisons = 0;

    always #10 sys_clk = ~sys_clk;

    pel_lane_ctrl #(.RESP_CYC(RESP)) pel_lane_ctrl_i (
        .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .tx_mode(tx_mode),
        .rx_mode(rx_mode), .tx_bit(tx_bit), .tx_diff_pos(tx_diff_pos), .tx_lane_on(tx_lane_on),
        .rx_diff_pos(rx_diff_pos), .rx_bit(rx_bit), .rx_energy_pin(rx_energy_pin),
        .lane_energy_seen(lane_energy_seen), .signal_ok(signal_ok), .loopback_on(loopback_on),
        .loopback_bit(loopback_bit), .fault_in(fault_in), .coef_req(coef_req),
        .coef_ack(coef_ack)
    );
    pel_partner pel_partner_i (
        .sys_clk(sys_clk), .tx_diff_pos(tx_diff_pos), .tx_lane_on(tx_lane_on), .wake(wake),
        .rx_diff_pos(rx_diff_pos), .rx_energy_pin(rx_energy_pin)
    );

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        step(1);
        reg_wr <= 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        reg_addr <= a;
        reg_rd <= 1'b1;
        step(1);
        reg_rd <= 1'b0;
        step(1);
        chk(what, exp, reg_rdata);
    endtask
    task automatic lanes(input logic [7:0] c, input logic [3:0] off, input logic [1:0] m,
                         input logic [3:0] e);
        wr(pel_pkg::ADDR_CTRL, c);
        wr(pel_pkg::ADDR_LANE_OFF, {4'h0, off});
        tx_mode <= m;
        step(3);
        chk("lane_on", {4'h0, e}, {4'h0, tx_lane_on});
        chk("loopback", {4'h0, tx_bit}, {4'h0, loopback_bit});
    endtask
    task automatic give_verdict;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        step(4);
        nrst <= 1'b1;
        step(1);
        rd(pel_pkg::ADDR_CTRL, pel_pkg::CTRL_RESET, "ctrl");
        rd(pel_pkg::ADDR_IRQ_MASK, pel_pkg::MASK_RESET, "mask");
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00, "unmapped");
        chk("signal_ok", 8'h00, {7'h0, signal_ok});
        tx_bit <= 4'hA;
        step(6);
        chk("tx_pos", 8'h0A, {4'h0, tx_diff_pos});
        chk("rx_bit", 8'h0A, {4'h0, rx_bit});
        $display("test registers and data done");
        lanes(8'h03, 4'h0, pel_pkg::TXM_DATA, 4'h0);
        lanes(8'h02, 4'h5, pel_pkg::TXM_DATA, 4'hA);
        lanes(8'h02, 4'h0, pel_pkg::TXM_QUIET, 4'h0);
        lanes(8'h02, 4'h0, pel_pkg::TXM_DATA, 4'hF);
        $display("test disables done");
        tx_mode <= pel_pkg::TXM_ALERT;
        step(1);
        for (int k = 0; k < 32; k++) begin
            step(1);
            chk("alert", ((k / 8) % 2 == 0) ? 8'h0F : 8'h00, {4'h0, tx_diff_pos});
        end
        lanes(8'h02, 4'h0, pel_pkg::TXM_QUIET, 4'h0);
        tx_mode <= pel_pkg::TXM_DATA;
        $display("test alert done");
        rx_mode <= pel_pkg::RXM_QUIET;
        wake <= 1'b1;
        for (int i = 0; i < pel_pkg::WAKE_DET_CYC && lane_energy_seen !== 4'hF; i++) step(1);
        chk("energy", 8'h0F, {4'h0, lane_energy_seen});
        step(2);
        chk("signal_ok", 8'h01, {7'h0, signal_ok});
        rd(pel_pkg::ADDR_STATUS, 8'h4F, "status");
        wake <= 1'b0;
        wr(pel_pkg::ADDR_CTRL, 8'h00);
        step(5);
        chk("forced", 8'h0F, {4'h0, lane_energy_seen});
        wr(pel_pkg::ADDR_CTRL, pel_pkg::CTRL_RESET);
        step(5);
        $display("test energy done");
        chk("irq", 8'h00, {7'h0, irq});
        wr(pel_pkg::ADDR_IRQ_MASK, 8'h01);
        step(1);
        chk("irq", 8'h01, {7'h0, irq});
        rd(pel_pkg::ADDR_IRQ_STAT, 8'h01, "irq_stat");
        step(1);
        chk("irq", 8'h00, {7'h0, irq});
        rd(pel_pkg::ADDR_IRQ_STAT, 8'h00, "irq_stat");
        $display("test interrupt done");
        for (int i = 0; i < 3; i++) begin
            fault_in <= 3'h1 << i;
            step(5);
            rd(pel_pkg::ADDR_FAULT, 8'h01 << i, "fault");
        end
        rd(pel_pkg::ADDR_IRQ_STAT, 8'h02, "irq_stat");
        fault_in <= 3'h0;
        coef_req <= 1'b1;
        step(1);
        coef_req <= 1'b0;
        for (int i = 0; i < RESP && coef_ack !== 1'b1; i++) step(1);
        chk("coef_ack", 8'h01, {7'h0, coef_ack});
        $display("test fault and training done");
        give_verdict();
    end
endmodule

// ### core/pel_lane_ctrl.sv
// Contract
// - In wake alert, every lane sends eight ones then eight zeros, repeating.
// - Logical one drives positive differential; positive differential received reads one.
// - Receive status is good when combined detect is one, fail otherwise.
// - Training switched off forces every lane energy flag to one.
// - Receive quiet: lane energy flag rises within 500 ns of wake signal.
// - Global transmit off turns off all four lane transmitters.
// - Global transmit off leaves loopback path untouched.
// - Transmit mode entering quiet turns all transmitters off.
// - Transmit mode leaving quiet turns all transmitters back on.
// - Lane transmit off disables only that lane's transmitter.
// - Lane transmit off leaves loopback path untouched.
// - Sublayer fault is reflected in the general fault status bit.
// - Transmit path fault is reflected in transmit fault status bit.
// - Receive path fault is reflected in receive fault status bit.
// - Each coefficient update request is answered within 2 ms.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module pel_lane_ctrl #(
    parameter int LANES    = pel_pkg::LANES,
    parameter int RESP_CYC = pel_pkg::RESP_LIMIT_CYC
) (
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    output logic                    irq,
    input  wire logic [1:0]         tx_mode,
    input  wire logic               rx_mode,
    input  wire logic [LANES-1:0]   tx_bit,
    output logic      [LANES-1:0]   tx_diff_pos,
    output logic      [LANES-1:0]   tx_lane_on,
    input  wire logic [LANES-1:0]   rx_diff_pos,
    output logic      [LANES-1:0]   rx_bit,
    input  wire logic [LANES-1:0]   rx_energy_pin,
    output logic      [LANES-1:0]   lane_energy_seen,
    output logic                    signal_ok,
    input  wire logic               loopback_on,
    output logic      [LANES-1:0]   loopback_bit,
    input  wire logic [2:0]         fault_in,
    input  wire logic               coef_req,
    output logic                    coef_ack
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    localparam int ENERGY_LAT = 3;

    initial begin
        if (LANES != pel_pkg::LANES) begin
            $error("Lane count must be four.");
        end
        if (RESP_CYC < 2) begin
            $error("Response limit too short.");
        end
        if (RESP_CYC > pel_pkg::RESP_LIMIT_CYC) begin
            $error("Response limit beyond two milliseconds.");
        end
        if (2 * pel_pkg::ALERT_HALF != int'(pel_pkg::ALERT_CNT_MAX) + 1) begin
            $error("Alert counter must wrap at one full period.");
        end
        if (pel_pkg::WAKE_DET_CYC < ENERGY_LAT) begin
            $error("Energy path slower than the wake limit.");
        end
    end

    localparam int RW = $clog2(RESP_CYC + 1);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic addr_is(input logic [3:0] addr, input logic [3:0] offset);
        return addr == offset;
    endfunction

    function automatic logic [LANES-1:0] lane_fill(input logic bit_in);
        return {LANES{bit_in}};
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [LANES-1:0] rx_diff_s;
    logic [LANES-1:0] energy_s;
    logic [2:0]       fault_s;

    pel_sync #(.W(2 * LANES + 3)) u_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       ({rx_diff_pos, rx_energy_pin, fault_in}),
        .q       ({rx_diff_s, energy_s, fault_s})
    );

    pel_pkg::pel_fault_s fault_w;
    assign fault_w = pel_pkg::pel_fault_s'(fault_s);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]       ctrl_reg;
    logic [7:0]       ctrl_next;
    logic [LANES-1:0] lane_off_reg;
    logic [LANES-1:0] lane_off_next;
    logic [7:0]       mask_reg;
    logic [7:0]       mask_next;
    logic [7:0]       stat_reg;
    logic [7:0]       stat_next;
    logic [7:0]       rdata_next;
    logic [3:0]       alert_cnt_reg;
    logic [1:0]       tx_mode_reg;
    logic             rx_mode_reg;
    logic             signal_ok_prev;
    logic             fault_prev;
    logic [RW-1:0]    resp_cnt_reg;
    logic [RW-1:0]    resp_cnt_next;
    logic             resp_busy_reg;
    logic             resp_late;

    // ------------------------------------------------------------
    // Address selects
    // ------------------------------------------------------------
    wire sel_ctrl     = addr_is(reg_addr, pel_pkg::ADDR_CTRL);
    wire sel_lane_off = addr_is(reg_addr, pel_pkg::ADDR_LANE_OFF);
    wire sel_fault    = addr_is(reg_addr, pel_pkg::ADDR_FAULT);
    wire sel_status   = addr_is(reg_addr, pel_pkg::ADDR_STATUS);
    wire sel_irq_stat = addr_is(reg_addr, pel_pkg::ADDR_IRQ_STAT);
    wire sel_irq_mask = addr_is(reg_addr, pel_pkg::ADDR_IRQ_MASK);

    wire all_tx_off  = ctrl_reg[pel_pkg::CTRL_TX_OFF];
    wire train_on    = ctrl_reg[pel_pkg::CTRL_TRAIN_ON];
    wire wr_ctrl     = reg_wr && sel_ctrl;
    wire wr_lane_off = reg_wr && sel_lane_off;
    wire wr_mask     = reg_wr && sel_irq_mask;
    wire rd_stat     = reg_rd && sel_irq_stat;

    assign ctrl_next     = wr_ctrl ? reg_wdata : ctrl_reg;
    assign lane_off_next = wr_lane_off ? reg_wdata[LANES-1:0] : lane_off_reg;
    assign mask_next     = wr_mask ? reg_wdata : mask_reg;

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    wire tx_quiet   = (tx_mode == 2'(pel_pkg::TXM_QUIET));
    wire tx_alert   = (tx_mode == 2'(pel_pkg::TXM_ALERT));
    wire alert_bit  = (alert_cnt_reg < 4'(pel_pkg::ALERT_HALF));

    wire [LANES-1:0] lane_on_next =
        lane_fill(!all_tx_off && !tx_quiet) & ~lane_off_reg;

    wire [LANES-1:0] tx_diff_next = tx_alert ? lane_fill(alert_bit) : tx_bit;

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    // Forced detect when training off; two-stage sync fits 500 ns.
    wire [LANES-1:0] energy_next = train_on ? energy_s : lane_fill(1'b1);
    wire             ok_next     = &lane_energy_seen;

    // ------------------------------------------------------------
    // Coefficient response timer
    // ------------------------------------------------------------
    wire resp_take   = coef_req && !resp_busy_reg;
    wire resp_expire = resp_busy_reg && (resp_cnt_reg == RW'(RESP_CYC - 2));
    assign resp_late = resp_expire;
    assign resp_cnt_next = resp_take ? '0 :
                           (resp_busy_reg ? resp_cnt_reg + RW'(1) : resp_cnt_reg);

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    wire [7:0] stat_set = {5'h00, resp_late, (|fault_s) && !fault_prev,
                           signal_ok != signal_ok_prev};
    assign stat_next = (rd_stat ? 8'h00 : stat_reg) | stat_set;

    // ------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------
    // Fault status bits.
    wire [7:0] fault_word  = {5'h00, fault_w.sublayer_fault, fault_w.tx_path_fault,
                              fault_w.rx_path_fault};
    wire [7:0] status_word = {1'b0, rx_mode_reg, tx_mode_reg, lane_energy_seen};

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_comb begin
        if (sel_ctrl) begin
            rdata_next = ctrl_reg;
        end else if (sel_lane_off) begin
            rdata_next = {4'h0, lane_off_reg};
        end else if (sel_fault) begin
            rdata_next = fault_word;
        end else if (sel_status) begin
            rdata_next = status_word;
        end else if (sel_irq_stat) begin
            rdata_next = stat_reg;
        end else if (sel_irq_mask) begin
            rdata_next = mask_reg;
        end else begin
            rdata_next = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Register flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg     <= pel_pkg::CTRL_RESET;
            lane_off_reg <= '0;
            mask_reg     <= pel_pkg::MASK_RESET;
        end else begin
            ctrl_reg     <= ctrl_next;
            lane_off_reg <= lane_off_next;
            mask_reg     <= mask_next;
        end
    end

    // ------------------------------------------------------------
    // Read port flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rdata_next : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Interrupt flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stat_reg <= 8'h00;
            irq      <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq      <= |(stat_next & mask_next);
        end
    end

    // ------------------------------------------------------------
    // Alert counter flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            alert_cnt_reg <= 4'h0;
        end else begin
            alert_cnt_reg <= tx_alert ? alert_cnt_reg + 4'h1 : 4'h0;
        end
    end

    // ------------------------------------------------------------
    // Transmit and mode flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_mode_reg <= 2'h0;
            rx_mode_reg <= 1'b0;
            tx_diff_pos <= '0;
            tx_lane_on  <= '0;
        end else begin
            tx_mode_reg <= tx_mode;
            rx_mode_reg <= rx_mode;
            tx_diff_pos <= tx_diff_next;
            tx_lane_on  <= lane_on_next;
        end
    end

    // ------------------------------------------------------------
    // Loopback flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            loopback_bit <= '0;
        end else begin
            loopback_bit <= loopback_on ? tx_diff_next : '0;
        end
    end

    // ------------------------------------------------------------
    // Receive flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_bit           <= '0;
            lane_energy_seen <= '0;
            signal_ok        <= 1'b0;
        end else begin
            rx_bit           <= rx_diff_s;
            lane_energy_seen <= energy_next;
            signal_ok        <= ok_next;
        end
    end

    // ------------------------------------------------------------
    // Event history flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            signal_ok_prev <= 1'b0;
            fault_prev     <= 1'b0;
        end else begin
            signal_ok_prev <= signal_ok;
            fault_prev     <= |fault_s;
        end
    end

    // ------------------------------------------------------------
    // Response timer flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            resp_cnt_reg  <= '0;
            resp_busy_reg <= 1'b0;
        end else begin
            resp_cnt_reg  <= resp_cnt_next;
            resp_busy_reg <= resp_take;
        end
    end

    // ------------------------------------------------------------
    // Response answer flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            coef_ack <= 1'b0;
        end else begin
            coef_ack <= resp_take && !resp_expire;
        end
    end

endmodule

// ### core/pel_pkg.sv
package pel_pkg;

    // ------------------------------------------------------------
    // Lane and pattern constants
    // ------------------------------------------------------------
    localparam int          LANES          = 4;
    localparam int          ALERT_HALF     = 8;
    localparam logic [3:0]  ALERT_CNT_MAX  = 4'hF;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          WAKE_DET_NS    = 500;
    localparam int          WAKE_DET_CYC   = WAKE_DET_NS / CLK_PERIOD_NS;
    localparam int          RESP_LIMIT_NS  = 2000000;
    localparam int          RESP_LIMIT_CYC = RESP_LIMIT_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL      = 4'h0;
    localparam logic [3:0]  ADDR_LANE_OFF  = 4'h1;
    localparam logic [3:0]  ADDR_FAULT     = 4'h2;
    localparam logic [3:0]  ADDR_STATUS    = 4'h3;
    localparam logic [3:0]  ADDR_IRQ_STAT  = 4'h4;
    localparam logic [3:0]  ADDR_IRQ_MASK  = 4'h5;
    localparam int          CTRL_TX_OFF    = 0;
    localparam int          CTRL_TRAIN_ON  = 1;
    localparam logic [7:0]  CTRL_RESET     = 8'h02;
    localparam logic [7:0]  MASK_RESET     = 8'h00;
    localparam int          IRQ_SIG_CHG    = 0;
    localparam int          IRQ_FAULT      = 1;
    localparam int          IRQ_RESP_LATE  = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TXM_DATA,
        TXM_QUIET,
        TXM_ALERT
    } pel_tx_mode_e;

    typedef enum logic {
        RXM_DATA,
        RXM_QUIET
    } pel_rx_mode_e;

    typedef struct packed {
        logic sublayer_fault;
        logic tx_path_fault;
        logic rx_path_fault;
    } pel_fault_s;

endpackage

// ### core/pel_sync.sv
`timescale 1ns/10ps
module pel_sync #(
    parameter int W = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;

    initial begin
        if (W < 1) begin
            $error("pel_sync width must be positive.");
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule
